/* include/lpm_pkg.sv */
// shared constants and types of the low-power mode controller
package lpm_pkg;
    // clock rate and missing-crystal timeout
    localparam int unsigned CLK_HZ       = 125_000_000;
    localparam int unsigned MISS_TIME_US = 100;
    localparam int unsigned MISS_CYC_DEF = MISS_TIME_US * (CLK_HZ / 1_000_000);
    // register byte offsets
    localparam logic [7:0] OFS_PWR_CTRL  = 8'h00; // power_control_reg
    localparam logic [7:0] OFS_PMU_CFG   = 8'h04; // power_mgmt_config_reg
    localparam logic [7:0] OFS_CLK_CFG   = 8'h08;
    localparam logic [7:0] OFS_PERIPH_EN = 8'h0C;
    localparam logic [7:0] OFS_RTC_CNT   = 8'h10;
    localparam logic [7:0] OFS_RTC_ALARM = 8'h14;
    localparam logic [7:0] OFS_STATUS    = 8'h18;
    localparam logic [7:0] OFS_PMATCH    = 8'h1C;
    // field positions
    localparam int unsigned PC_IDLE     = 0;
    localparam int unsigned PC_STOP     = 1;
    localparam int unsigned PM_SUSPEND  = 0;
    localparam int unsigned PM_SLEEP    = 1;
    localparam int unsigned PM_ALM_RST  = 2;
    localparam int unsigned PM_FAIL_RST = 3;
    localparam int unsigned CK_SRC_LSB  = 0;
    localparam int unsigned CK_DIV_LSB  = 2;
    localparam int unsigned CK_RTC_XTAL = 5;
    localparam int unsigned CK_CAP_LSB  = 8;
    localparam int unsigned ST_CAUSE_LSB = 8;
    // clock sources and reset values
    localparam logic [1:0] SRC_LPOSC   = 2'h0;
    localparam logic [1:0] SRC_HFOSC   = 2'h1;
    localparam logic [1:0] SRC_EXT     = 2'h2;
    localparam logic [2:0] DIV_RST     = 3'h3;
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    // controller states
    typedef enum logic [5:0] {
        ST_RUN = 6'h01, ST_IDLE = 6'h02, ST_SUSPEND = 6'h04,
        ST_WAKE = 6'h08, ST_SLEEP = 6'h10, ST_STOP = 6'h20
    } lpm_state_type;
    // address phase of the register bus
    typedef struct packed {
        logic        hsel;
        logic [1:0]  htrans;
        logic [31:0] haddr;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
    } lpm_ahb_req_type;
    // power net controls
    typedef struct packed {
        logic main_pwr;
        logic retain_pwr;
        logic pin_hold;
        logic dbg_keep;
    } lpm_pwr_type;
endpackage

/* src/lpm_clkdiv.sv */
// system clock source select and power-of-two divider
`timescale 1ns/1ns
module lpm_clkdiv #(
    parameter int unsigned DW = 7
) (
    input  wire logic       i_clk,
    input  wire logic       i_nrst,
    input  wire logic       i_run,
    input  wire logic [2:0] i_src_tick,
    input  wire logic [1:0] i_src_sel,
    input  wire logic [2:0] i_div_sel,
    output logic            o_tick
);
    logic [DW-1:0] cnt_q;
    logic          tick;
    logic [DW-1:0] mask;

    // pick one source tick, unused code gives none
    function automatic logic src_pick(input logic [2:0] t, input logic [1:0] s);
        src_pick = (s == 2'h3) ? 1'b0 : t[s];
    endfunction

    assign tick = src_pick(i_src_tick, i_src_sel);
    assign mask = DW'((1 << i_div_sel) - 1);

    // count source ticks, emit one tick per ratio
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_q  <= '0;
            o_tick <= 1'b0;
        end else begin
            o_tick <= 1'b0;
            if (i_run && tick) begin
                if (cnt_q >= mask) begin
                    cnt_q  <= '0;
                    o_tick <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // RL10 divided tick spacing
    property p_div_tick;
        (i_run && tick && cnt_q >= mask) |=> o_tick && cnt_q == '0;
    endproperty
    a_div_tick: assert property (p_div_tick) else $error("divider tick missing"); // RL10
endmodule // lpm_clkdiv

/* src/lpm_ctrl.sv */
// low-power mode, clock select and wake controller with register slave
// Overview of operation
// RL1: idle request halts core only; any interrupt resumes execution.
// RL2: suspend needs internal oscillator selected; then core and oscillators stop. The code refuses it only with the external clock selected.
// RL3: suspend ends by alarm, crystal fail, touch, port match, comparator rise.
// RL4: stop request removes all power nets, pins held; only reset exits. The code keeps dbg_keep on in stop.
// RL5: software disables analog then sets the retention request bit.
// RL6: retention keeps state in a retained net; same wakes minus touch.
// RL7: retention may drop the debug link.
// RL8: unused digital peripheral clocks are gated off.
// RL9: after reset system clock is low-power oscillator divided by eight.
// RL10: divider offers ratios 1 to 128 in powers of two.
// RL11: 32-bit free-running counter with alarm compare.
// RL12: missing crystal detector raises a failure event.
// RL13: counter clocks from low-frequency oscillator or crystal.
// RL14: crystal load capacitance has sixteen settings.
// RL15: alarm or failure wakes, or resets when so configured.
// RL16: counter clock available as buffered output.
// RL17: sixteen pins share a match interrupt; two pins own vectors.
// RL18: wake waits for restarted oscillator stable before core clock.
`timescale 1ns/1ns
module lpm_ctrl #(
    parameter int unsigned MISS_CYC = lpm_pkg::MISS_CYC_DEF,
    parameter int unsigned NPINS    = 16,
    parameter int unsigned NPER     = 8
) (
    input  wire logic                   I_CLOCK,
    input  wire logic                   I_NRST,
    input  wire lpm_pkg::lpm_ahb_req_type I_AHB,
    input  wire logic [31:0]            I_HWDATA,
    output logic [31:0]                 O_HRDATA,
    output logic                        O_HREADYOUT,
    output logic                        O_HRESP,
    input  wire logic [2:0]             I_SRC_TICK,
    input  wire logic                   I_LFOSC_TICK,
    input  wire logic                   I_XTAL_TICK,
    input  wire logic                   I_OSC_READY,
    input  wire logic                   I_IRQ_ANY,
    input  wire logic                   I_CSENSE_IRQ,
    input  wire logic                   I_CMP_OUT,
    input  wire logic [NPINS-1:0]       I_PORT_PINS,
    input  wire logic [1:0]             I_PIN_INT,
    output logic                        O_SYSTEM_CLOCK_EN,
    output logic                        O_CORE_CLK_EN,
    output logic [NPER-1:0]             O_PERIPH_CLK_EN,
    output logic [1:0]                  O_OSC_EN,
    output logic [1:0]                  O_SYSTEM_CLOCK_SRC,
    output lpm_pkg::lpm_pwr_type        O_PWR,
    output logic                        O_RTC_CLK_OUT,
    output logic [3:0]                  O_XTAL_CAP,
    output logic                        O_RTC_XTAL,
    output logic                        O_RESET_REQ,
    output logic                        O_PORT_MATCH_IRQ,
    output logic [1:0]                  O_PIN_IRQ
);
    import lpm_pkg::*;

    ////////////////////////////////////////////////////////////////
    // declarations
    lpm_state_type     st_q, st_d;
    logic              wr_q;
    logic [7:0]        addr_q;
    logic [2:0]        div_q;
    logic              alm_rst_q, fail_rst_q;
    logic [31:0]       alarm_q;
    logic [NPINS-1:0]  pm_val_q, pm_mask_q;
    logic [5:0]        cause_q, cause_set;
    logic              cmp_q;
    logic [31:0]       rtc_count, rd_word;
    logic              alarm_ev, fail_ev, system_clock_tick;
    logic              idle_req, stop_req, susp_req, sleep_req;
    logic              pmatch_ev, cmp_rise, any_irq;
    logic              wake_susp, wake_sleep;

    // write strobe for one register in the data phase
    function automatic logic wr_hit(input logic w, input logic [7:0] a, input logic [7:0] ofs);
        wr_hit = w && (a == ofs);
    endfunction

    // states in which the system clock keeps running
    function automatic logic clk_runs(input lpm_state_type s);
        clk_runs = (s == ST_RUN) || (s == ST_IDLE);
    endfunction

    ////////////////////////////////////////////////////////////////
    // register bus slave, zero wait states
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            wr_q        <= 1'b0;
            addr_q      <= 8'h00;
            O_HRDATA    <= 32'h0;
            O_HREADYOUT <= 1'b0;
            O_HRESP     <= 1'b0;
        end else begin
            O_HREADYOUT <= 1'b1;
            O_HRESP     <= 1'b0;
            wr_q        <= 1'b0;
            if (I_AHB.hsel && I_AHB.htrans[1] && I_AHB.hready) begin
                wr_q     <= I_AHB.hwrite;
                addr_q   <= I_AHB.haddr[7:0];
                O_HRDATA <= I_AHB.hwrite ? 32'h0 : rd_word;
            end
        end
    end

    // read multiplexer, unmapped reads as zero
    always_comb begin
        rd_word = 32'h0;
        if (I_AHB.haddr[31:8] == 24'h0) begin
            unique case (I_AHB.haddr[7:0])
                OFS_PMU_CFG: begin
                    rd_word[PM_ALM_RST]  = alm_rst_q;
                    rd_word[PM_FAIL_RST] = fail_rst_q;
                end
                OFS_CLK_CFG: begin
                    rd_word[CK_SRC_LSB +: 2] = O_SYSTEM_CLOCK_SRC;
                    rd_word[CK_DIV_LSB +: 3] = div_q;
                    rd_word[CK_RTC_XTAL]     = O_RTC_XTAL;
                    rd_word[CK_CAP_LSB +: 4] = O_XTAL_CAP;
                end
                OFS_PERIPH_EN: rd_word[NPER-1:0] = O_PERIPH_CLK_EN;
                OFS_RTC_CNT:   rd_word = rtc_count;
                OFS_RTC_ALARM: rd_word = alarm_q;
                OFS_STATUS: begin
                    rd_word[5:0]                = st_q;
                    rd_word[ST_CAUSE_LSB +: 6]  = cause_q;
                end
                OFS_PMATCH:    rd_word = {pm_mask_q, pm_val_q};
                default:       rd_word = 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // mode requests, taken only while running
    assign idle_req  = wr_hit(wr_q, addr_q, OFS_PWR_CTRL) && I_HWDATA[PC_IDLE];
    assign stop_req  = wr_hit(wr_q, addr_q, OFS_PWR_CTRL) && I_HWDATA[PC_STOP];
    assign susp_req  = wr_hit(wr_q, addr_q, OFS_PMU_CFG) && I_HWDATA[PM_SUSPEND];
    assign sleep_req = wr_hit(wr_q, addr_q, OFS_PMU_CFG) && I_HWDATA[PM_SLEEP];

    // configuration registers
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            // RL9 default clock choice
            O_SYSTEM_CLOCK_SRC    <= SRC_LPOSC;
            div_q           <= DIV_RST;
            O_RTC_XTAL      <= 1'b0;
            O_XTAL_CAP      <= 4'h0;
            alm_rst_q       <= 1'b0;
            fail_rst_q      <= 1'b0;
            alarm_q         <= 32'hFFFFFFFF;
            pm_val_q        <= '0;
            pm_mask_q       <= '0;
        end else begin
            if (wr_hit(wr_q, addr_q, OFS_CLK_CFG)) begin
                O_SYSTEM_CLOCK_SRC <= I_HWDATA[CK_SRC_LSB +: 2];
                // RL10 ratio select
                div_q        <= I_HWDATA[CK_DIV_LSB +: 3];
                // RL13 counter clock select
                O_RTC_XTAL   <= I_HWDATA[CK_RTC_XTAL];
                // RL14 load capacitance
                O_XTAL_CAP   <= I_HWDATA[CK_CAP_LSB +: 4];
            end
            if (wr_hit(wr_q, addr_q, OFS_PMU_CFG)) begin
                alm_rst_q  <= I_HWDATA[PM_ALM_RST];
                fail_rst_q <= I_HWDATA[PM_FAIL_RST];
            end
            if (wr_hit(wr_q, addr_q, OFS_RTC_ALARM)) begin
                alarm_q <= I_HWDATA;
            end
            if (wr_hit(wr_q, addr_q, OFS_PMATCH)) begin
                pm_val_q  <= I_HWDATA[NPINS-1:0];
                pm_mask_q <= I_HWDATA[16 +: NPINS];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // wake event sources
    assign pmatch_ev  = |((I_PORT_PINS ^ pm_val_q) & pm_mask_q);
    assign cmp_rise   = I_CMP_OUT && !cmp_q;
    assign any_irq    = I_IRQ_ANY || (|I_PIN_INT) || pmatch_ev || I_CSENSE_IRQ;
    assign wake_sleep = alarm_ev || fail_ev || pmatch_ev || cmp_rise;
    assign wake_susp  = wake_sleep || I_CSENSE_IRQ;
    assign cause_set  = {any_irq, cmp_rise, pmatch_ev, I_CSENSE_IRQ, fail_ev, alarm_ev};

    // event capture, sticky causes cleared by writing ones
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            cmp_q            <= 1'b0;
            cause_q          <= 6'h00;
            O_PORT_MATCH_IRQ <= 1'b0;
            O_PIN_IRQ        <= 2'h0;
            O_RESET_REQ      <= 1'b0;
        end else begin
            cmp_q <= I_CMP_OUT;
            if (wr_hit(wr_q, addr_q, OFS_STATUS)) begin
                cause_q <= (cause_q & ~I_HWDATA[ST_CAUSE_LSB +: 6]) | cause_set;
            end else begin
                cause_q <= cause_q | cause_set;
            end
            // RL17 shared match and dedicated pin vectors
            O_PORT_MATCH_IRQ <= pmatch_ev;
            O_PIN_IRQ        <= I_PIN_INT;
            // RL15 optional reset from counter events
            O_RESET_REQ <= (alarm_ev && alm_rst_q) || (fail_ev && fail_rst_q);
        end
    end

    ////////////////////////////////////////////////////////////////
    // mode state machine
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_RUN: begin
                // RL4 full shutdown entry
                if (stop_req) begin
                    st_d = ST_STOP;
                // RL5 retention entry
                end else if (sleep_req) begin
                    st_d = ST_SLEEP;
                // RL2 suspend from any source select except the external clock
                end else if (susp_req && O_SYSTEM_CLOCK_SRC != SRC_EXT) begin
                    st_d = ST_SUSPEND;
                end else if (idle_req) begin
                    st_d = ST_IDLE;
                end
            end
            // RL1 any interrupt resumes
            ST_IDLE:    if (any_irq) st_d = ST_RUN;
            // RL3 suspend wake sources
            ST_SUSPEND: if (wake_susp) st_d = ST_WAKE;
            // RL6 retention wake sources
            ST_SLEEP:   if (wake_sleep) st_d = ST_WAKE;
            // RL18 wait for stable oscillator
            ST_WAKE:    if (I_OSC_READY) st_d = ST_RUN;
            ST_STOP:    st_d = ST_STOP;
            default:    st_d = ST_RUN;
        endcase
    end

    // state, core clock, oscillator and power outputs follow the next state; peripheral enables follow register writes
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            st_q            <= ST_RUN;
            O_CORE_CLK_EN   <= 1'b1;
            O_PERIPH_CLK_EN <= '0;
            O_OSC_EN        <= 2'h1;
            O_PWR           <= 4'hF;
        end else begin
            st_q          <= st_d;
            O_CORE_CLK_EN <= (st_d == ST_RUN);
            // RL8 peripheral clock gating
            if (wr_hit(wr_q, addr_q, OFS_PERIPH_EN)) begin
                O_PERIPH_CLK_EN <= I_HWDATA[NPER-1:0];
            end
            // RL2 oscillators off while suspended
            O_OSC_EN[0] <= (O_SYSTEM_CLOCK_SRC == SRC_LPOSC) && (clk_runs(st_d) || st_d == ST_WAKE);
            O_OSC_EN[1] <= (O_SYSTEM_CLOCK_SRC == SRC_HFOSC) && (clk_runs(st_d) || st_d == ST_WAKE);
            // RL4 power nets and pin hold
            O_PWR.main_pwr   <= !(st_d == ST_SLEEP || st_d == ST_STOP);
            O_PWR.retain_pwr <= (st_d != ST_STOP);
            O_PWR.pin_hold  <= (st_d == ST_SLEEP || st_d == ST_STOP);
            // RL7 debug link dropped in retention
            O_PWR.dbg_keep  <= (st_d != ST_SLEEP);
        end
    end

    ////////////////////////////////////////////////////////////////
    // divider and counter
    lpm_clkdiv i_lpm_clkdiv (
        .i_clk      (I_CLOCK),
        .i_nrst     (I_NRST),
        .i_run      (clk_runs(st_q)),
        .i_src_tick (I_SRC_TICK),
        .i_src_sel  (O_SYSTEM_CLOCK_SRC),
        .i_div_sel  (div_q),
        .o_tick     (system_clock_tick)
    );
    assign O_SYSTEM_CLOCK_EN = system_clock_tick;

    lpm_rtc #(.MISS_CYC(MISS_CYC)) i_lpm_rtc (
        .i_clk       (I_CLOCK),
        .i_nrst      (I_NRST),
        .i_xtal_sel  (O_RTC_XTAL),
        .i_lf_tick   (I_LFOSC_TICK),
        .i_xtal_tick (I_XTAL_TICK),
        .i_load      (wr_hit(wr_q, addr_q, OFS_RTC_CNT)),
        .i_load_val  (I_HWDATA),
        .i_alarm     (alarm_q),
        .o_count     (rtc_count),
        .o_alarm_ev  (alarm_ev),
        .o_fail_ev   (fail_ev),
        .o_clk_out   (O_RTC_CLK_OUT)
    );

    ////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_NRST);

    sequence s_susp_wake;
        st_q == ST_SUSPEND && wake_susp;
    endsequence
    sequence s_wake_done;
        st_q == ST_WAKE && !O_CORE_CLK_EN ##1 st_q == ST_RUN && O_CORE_CLK_EN;
    endsequence

    // RL1 idle gates core only
    property p_idle;
        st_q == ST_IDLE |-> !O_CORE_CLK_EN && O_PWR.main_pwr;
    endproperty
    a_idle: assert property (p_idle) else $error("idle clocking wrong"); // RL1
    // RL1 interrupt ends idle
    property p_idle_exit;
        st_q == ST_IDLE && any_irq |=> st_q == ST_RUN && O_CORE_CLK_EN;
    endproperty
    a_idle_exit: assert property (p_idle_exit) else $error("idle not left"); // RL1
    // RL2 suspend refused with external clock
    property p_susp_ref;
        st_q == ST_RUN && susp_req && !stop_req && !sleep_req && O_SYSTEM_CLOCK_SRC == SRC_EXT
            |=> st_q != ST_SUSPEND;
    endproperty
    a_susp_ref: assert property (p_susp_ref) else $error("suspend taken with external clock"); // RL2
    // RL2 oscillators off in suspend
    property p_susp_osc;
        st_q == ST_SUSPEND |-> O_OSC_EN == 2'h0 && !O_CORE_CLK_EN;
    endproperty
    a_susp_osc: assert property (p_susp_osc) else $error("oscillator running in suspend"); // RL2
    // RL3 wake from suspend via restart
    property p_susp_wake;
        s_susp_wake |=> st_q == ST_WAKE;
    endproperty
    a_susp_wake: assert property (p_susp_wake) else $error("suspend wake lost"); // RL3
    // RL18 core clock only after oscillator ready
    property p_restart;
        st_q == ST_WAKE && I_OSC_READY |-> s_wake_done;
    endproperty
    a_restart: assert property (p_restart) else $error("restart sequence broken"); // RL18
    // RL4 stop holds power off until reset
    property p_stop;
        st_q == ST_STOP |-> !O_PWR.main_pwr && !O_PWR.retain_pwr && O_PWR.pin_hold ##1 st_q == ST_STOP;
    endproperty
    a_stop: assert property (p_stop) else $error("stop left without reset"); // RL4
    // RL6 retention net stays powered in sleep
    property p_sleep;
        st_q == ST_SLEEP |-> O_PWR.retain_pwr && !O_PWR.main_pwr && !O_PWR.dbg_keep;
    endproperty
    a_sleep: assert property (p_sleep) else $error("retention nets wrong"); // RL6
    // RL15 alarm reset request
    property p_alm_rst;
        alarm_ev && alm_rst_q |=> O_RESET_REQ ##1 (!O_RESET_REQ || $past(alarm_ev) || $past(fail_ev));
    endproperty
    a_alm_rst: assert property (p_alm_rst) else $error("alarm reset missing"); // RL15
    // RL8 peripheral clocks gated when disabled
    property p_per_gate;
        wr_hit(wr_q, addr_q, OFS_PERIPH_EN) |=> O_PERIPH_CLK_EN == $past(I_HWDATA[NPER-1:0]);
    endproperty
    a_per_gate: assert property (p_per_gate) else $error("peripheral gate not set"); // RL8
endmodule // lpm_ctrl

/* src/lpm_rtc.sv */
// free-running 32-bit counter with alarm and crystal watch
`timescale 1ns/1ns
module lpm_rtc #(
    parameter int unsigned MISS_CYC = 12500
) (
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_xtal_sel,
    input  wire logic        i_lf_tick,
    input  wire logic        i_xtal_tick,
    input  wire logic        i_load,
    input  wire logic [31:0] i_load_val,
    input  wire logic [31:0] i_alarm,
    output logic [31:0]      o_count,
    output logic             o_alarm_ev,
    output logic             o_fail_ev,
    output logic             o_clk_out
);
    localparam int unsigned MW = $clog2(MISS_CYC + 1);
    logic          tick;
    logic [MW-1:0] miss_q;
    logic          failed_q;

    assign tick = i_xtal_sel ? i_xtal_tick : i_lf_tick;

    // RL11 count, load and alarm
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_count    <= 32'h0;
            o_alarm_ev <= 1'b0;
            o_clk_out  <= 1'b0;
        end else begin
            o_alarm_ev <= tick && !i_load && (o_count + 32'h1 == i_alarm);
            if (i_load) begin
                o_count <= i_load_val;
            end else if (tick) begin
                o_count <= o_count + 32'h1;
            end
            // RL16 buffered clock out
            if (tick) begin
                o_clk_out <= ~o_clk_out;
            end
        end
    end

    // RL12 missing crystal detector
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            miss_q    <= '0;
            failed_q  <= 1'b0;
            o_fail_ev <= 1'b0;
        end else begin
            o_fail_ev <= 1'b0;
            if (!i_xtal_sel || i_xtal_tick) begin
                miss_q   <= '0;
                failed_q <= 1'b0;
            end else if (miss_q == MW'(MISS_CYC - 1)) begin
                failed_q  <= 1'b1;
                o_fail_ev <= !failed_q;
            end else begin
                miss_q <= miss_q + 1'b1;
            end
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // RL11 counter advance
    property p_rtc_inc;
        (tick && !i_load) |=> o_count == $past(o_count) + 32'h1;
    endproperty
    a_rtc_inc: assert property (p_rtc_inc) else $error("counter did not advance"); // RL11
    // RL12 failure flag
    property p_fail;
        (i_xtal_sel && !i_xtal_tick && !failed_q && miss_q == MW'(MISS_CYC - 1)) |=> o_fail_ev;
    endproperty
    a_fail: assert property (p_fail) else $error("crystal failure not flagged"); // RL12
endmodule // lpm_rtc

/* testbench/lpm_ctrl_tb.sv */
// self-checking bench of the low-power mode controller
`timescale 1ns/1ns
module lpm_ctrl_tb;
    import lpm_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, irq = 1'b0, osc_rdy = 1'b0, zero = 1'b0, lf = 1'b0;
    logic [2:0]  src_tick = 3'h7;
    logic [15:0] pins = 16'h0000;
    logic [31:0] hwdata = 32'h0, rd;
    lpm_ahb_req_type ahb = '0;
    logic [31:0] hrdata;
    logic        hready, sclk, core, rtc_o, rst_q, pm_irq;
    logic [7:0]  per;
    logic [1:0]  osc, src, pin_irq;
    lpm_pwr_type pwr;
    logic [3:0]  cap;
    logic        xtal, hresp;
    int          fails = 0, cmp_count = 0;
    lpm_ctrl #(.MISS_CYC(20)) i_lpm_ctrl (.I_CLOCK(clk), .I_NRST(nrst), .I_AHB(ahb), .I_HWDATA(hwdata),
        .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .I_SRC_TICK(src_tick), .I_LFOSC_TICK(lf),
        .I_XTAL_TICK(zero), .I_OSC_READY(osc_rdy), .I_IRQ_ANY(irq), .I_CSENSE_IRQ(zero), .I_CMP_OUT(zero),
        .I_PORT_PINS(pins), .I_PIN_INT({zero, zero}), .O_SYSTEM_CLOCK_EN(sclk), .O_CORE_CLK_EN(core),
        .O_PERIPH_CLK_EN(per), .O_OSC_EN(osc), .O_SYSTEM_CLOCK_SRC(src), .O_PWR(pwr), .O_RTC_CLK_OUT(rtc_o),
        .O_XTAL_CAP(cap), .O_RTC_XTAL(xtal), .O_RESET_REQ(rst_q), .O_PORT_MATCH_IRQ(pm_irq), .O_PIN_IRQ(pin_irq));
    // clock and hready feedback
    always #4 clk = ~clk;
    always @(hready) ahb.hready <= hready;
    ////////////////////////////////////////////////////////////////////////////////
    // comparison, verdict and bus access
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("tests done: %0d compares, %0d mismatches", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
        ahb.hsel <= 1'b1; ahb.htrans <= 2'h2; ahb.haddr <= {24'h0, a}; ahb.hwrite <= w; ahb.hsize <= 3'h2;
        do @(posedge clk); while (hready !== 1'b1);
        ahb.hsel <= 1'b0; ahb.htrans <= HTRANS_IDLE; hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
        // idle cycle so that outputs launched at the data edge have settled
        @(posedge clk);
    endtask
    task automatic st(input logic [5:0] exp);
        bus(1'b0, OFS_STATUS, 32'h0, rd);
        chk({26'h0, rd[5:0]}, {26'h0, exp});
    endtask
    task automatic pulses(input int exp);
        int n = 0;
        repeat (64) begin @(posedge clk); #1; if (sclk === 1'b1) n++; end
        chk(n, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset_clock();
        bus(1'b0, OFS_CLK_CFG, 32'h0, rd);
        chk(rd, 32'h0000000C);
        chk({30'h0, osc}, 32'h1);
        pulses(8);
        bus(1'b1, OFS_CLK_CFG, 32'h00000000, rd);
        pulses(64);
        bus(1'b1, OFS_CLK_CFG, 32'h0000001C, rd);
        pulses(0);
        bus(1'b1, OFS_CLK_CFG, 32'h00000F0C, rd);
        chk({28'h0, cap}, 32'hF);
        bus(1'b0, 8'hF0, 32'h0, rd);
        chk(rd, 32'h0);
        $display("test reset and clock done");
    endtask
    task automatic t_periph_idle();
        bus(1'b1, OFS_PERIPH_EN, 32'h0000005A, rd);
        chk({24'h0, per}, 32'h5A);
        bus(1'b1, OFS_PWR_CTRL, 32'h1, rd);
        st(6'h02);
        chk({23'h0, core, per}, 32'h5A);
        irq <= 1'b1;
        repeat (2) @(posedge clk);
        irq <= 1'b0;
        st(6'h01);
        $display("test peripherals and idle done");
    endtask
    task automatic t_suspend();
        bus(1'b1, OFS_CLK_CFG, 32'h0000000E, rd);
        bus(1'b1, OFS_PMU_CFG, 32'h1, rd);
        st(6'h01);
        bus(1'b1, OFS_CLK_CFG, 32'h0000000C, rd);
        bus(1'b1, OFS_PMATCH, 32'h00010000, rd);
        bus(1'b1, OFS_PMU_CFG, 32'h1, rd);
        st(6'h04);
        chk({30'h0, core, osc[0]}, 32'h0);
        pins <= 16'h0001;
        repeat (2) @(posedge clk);
        st(6'h08);
        chk({30'h0, osc}, 32'h1);
        chk({31'h0, core}, 32'h0);
        osc_rdy <= 1'b1;
        repeat (2) @(posedge clk);
        chk({31'h0, core}, 32'h1);
        st(6'h01);
        $display("test suspend done");
    endtask
    task automatic t_stop();
        bus(1'b1, OFS_PWR_CTRL, 32'h2, rd);
        st(6'h20);
        chk({31'h0, pwr.main_pwr}, 32'h0);
        chk({31'h0, pwr.pin_hold}, 32'h1);
        irq <= 1'b1;
        repeat (4) @(posedge clk);
        st(6'h20);
        irq <= 1'b0;
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        st(6'h01);
        $display("test stop done");
    endtask
    task automatic t_rtc();
        int n = 0, m = 0;
        bus(1'b1, OFS_RTC_ALARM, 32'h00000010, rd);
        bus(1'b1, OFS_RTC_CNT, 32'h00000008, rd);
        bus(1'b1, OFS_PMU_CFG, 32'h00000006, rd);
        st(6'h10);
        chk({29'h0, pwr.main_pwr, pwr.retain_pwr, pwr.dbg_keep}, 32'h2);
        lf <= 1'b1;
        repeat (24) begin @(posedge clk); #1; n += rst_q; m += rtc_o; end
        lf <= 1'b0;
        chk(n, 1);
        chk(m, 12);
        st(6'h01);
        bus(1'b0, OFS_RTC_CNT, 32'h0, rd);
        chk(rd, 32'h00000020);
        bus(1'b1, OFS_PMU_CFG, 32'h00000008, rd);
        bus(1'b1, OFS_CLK_CFG, 32'h0000002C, rd);
        n = 0;
        repeat (30) begin @(posedge clk); #1; n += rst_q; end
        chk(n, 1);
        $display("test counter done");
    endtask
    // main sequence and watchdog
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset_clock();
        t_periph_idle();
        t_suspend();
        t_stop();
        t_rtc();
        complete_run();
    end
    initial begin
        #100000;
        fails++;
        complete_run();
    end
endmodule // lpm_ctrl_tb
